// File: hw/gcas_top.sv
// Global command register, alarm status and peak registers behind the serial port
// What this block does
// - Writing one to a command bit starts it; bit self-clears; 0 autonull, 15 clears it.
// - Bit 14 loads alarm band settings chosen by alarm band pointer.
// - Bit 13 fetches stored record data from flash for readback.
// - Bit 12 saves alarm band registers into flash.
// - Bit 11 toggles recording: idle starts, recording stops.
// - Bit 10 forces buffer pointer index to zero.
// - Bit 9 erases stored band settings; bit 8 erases all records.
// - Bit 7 software reset; bit 6 saves register settings to flash.
// - Bit 5 runs flash checksum test against factory value.
// - Bit 4 clears diagnostic status once; later flags report again.
// - Bit 3 restores factory settings and empties capture buffers.
// - Bit 2 runs self test; failure sets diagnostic bit 5.
// - Bit 1 powers down sensor and sleeps the controller.
// - Power-down ends on chip select toggle or automatic capture timer.
// - Alarm status bits 15..4 hold two flags per band, alarm 1 lower.
// - Bit 3 unused; bits 2..0 give most critical band 1..6.
// - Peak register reads x-axis peak alarm bin magnitude, read-only.
// - Diagnostic bit 6 is zero on checksum match, one on error.
`timescale 1ns/100ps
`default_nettype none

`include "gcas_params.svh"

module gcas_top
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  // Serial port pins, mode 3, 16-bit frames
  input wire logic i_spi_cs_n,
  input wire logic i_spi_sclk,
  input wire logic i_spi_mosi,
  output logic o_spi_miso,
  output logic o_spi_miso_oe_n,
  // Alarm results from the spectral engine
  input wire logic [5:0] i_alarm1_x,
  input wire logic [5:0] i_alarm2_x,
  input wire logic [2:0] i_worst_band_x,
  input wire logic [5:0] i_alarm1_y,
  input wire logic [5:0] i_alarm2_y,
  input wire logic [2:0] i_worst_band_y,
  input wire logic [5:0] i_alarm1_z,
  input wire logic [5:0] i_alarm2_z,
  input wire logic [2:0] i_worst_band_z,
  input wire logic [15:0] i_peak_x,
  input wire logic i_alarm_update,
  // Process results
  input wire logic i_self_test_done,
  input wire logic i_self_test_fail,
  input wire logic i_flash_test_done,
  input wire logic i_flash_test_fail,
  input wire logic [15:0] i_diag_flags,
  input wire logic i_auto_timer_fire,
  // Command strobes, recording and power-down levels, and diagnostic status word
  output logic o_autonull,
  output logic o_autonull_clear,
  output logic o_self_test_start,
  output logic o_factory_restore,
  output logic o_buffer_clear,
  output logic o_flash_test_start,
  output logic o_save_registers,
  output logic o_software_reset,
  output logic o_clear_records,
  output logic o_clear_bands,
  output logic o_record_start,
  output logic o_record_stop,
  output logic o_save_bands,
  output logic o_fetch_record,
  output logic o_load_bands,
  output logic o_buffer_pointer_zero,
  output logic o_recording,
  output logic o_power_down,
  output logic [15:0] o_diagnostic_status
);

  // ==========================================================
  // Pin synchronisers
  logic cs_n_s;
  logic sclk_s;
  logic mosi_s;

  gcas_sync u_sync_cs
  (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_async(i_spi_cs_n),
    .o_sync(cs_n_s)
  );

  gcas_sync u_sync_sclk
  (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_async(i_spi_sclk),
    .o_sync(sclk_s)
  );

  gcas_sync u_sync_mosi
  (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_async(i_spi_mosi),
    .o_sync(mosi_s)
  );

  // ==========================================================
  // Edge detection on synchronised levels
  logic sclk_d_ff;
  logic cs_d_ff;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      sclk_d_ff <= 1'b1;
      cs_d_ff <= 1'b1;
    end
    else
    begin
      sclk_d_ff <= sclk_s;
      cs_d_ff <= cs_n_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_d_ff;
  assign sclk_fall = ~sclk_s & sclk_d_ff;
  assign cs_fall = ~cs_n_s & cs_d_ff;
  assign cs_rise = cs_n_s & ~cs_d_ff;

  // ==========================================================
  // Frame shifter
  gcas_pkg::gcas_spi_state_t state_ff;
  logic [15:0] rx_ff;
  logic [15:0] tx_ff;
  logic [4:0] bit_cnt_ff;
  logic [6:0] rd_addr_ff;
  logic frame_done;
  logic [15:0] nxt_rx;

  assign nxt_rx = {rx_ff[14:0], mosi_s};
  assign frame_done = sclk_rise && (bit_cnt_ff == 5'h0F);

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
      state_ff <= gcas_pkg::GCAS_SPI_IDLE;
    else if (cs_n_s)
      state_ff <= gcas_pkg::GCAS_SPI_IDLE;
    else
    begin
      unique case (state_ff)
        gcas_pkg::GCAS_SPI_IDLE: state_ff <= gcas_pkg::GCAS_SPI_SHIFT;
        gcas_pkg::GCAS_SPI_SHIFT:
          if (frame_done)
            state_ff <= gcas_pkg::GCAS_SPI_DONE;
        gcas_pkg::GCAS_SPI_DONE: state_ff <= gcas_pkg::GCAS_SPI_SHIFT;
      endcase
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
      bit_cnt_ff <= 5'h00;
    else if (cs_n_s)
      bit_cnt_ff <= 5'h00;
    else if (sclk_rise)
      bit_cnt_ff <= (bit_cnt_ff == 5'h0F) ? 5'h00 : bit_cnt_ff + 5'h01;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
      rx_ff <= `GCAS_RESET_VALUE;
    else if (sclk_rise)
      rx_ff <= nxt_rx;
  end

  // ==========================================================
  // Frame decode: bit 15 write, [14:8] address, [7:0] data
  logic wr_frame;
  logic rd_frame;
  logic [6:0] f_addr;
  logic [7:0] f_data;
  logic wr_cmd_lo;
  logic wr_cmd_hi;

  assign f_addr = nxt_rx[14:8];
  assign f_data = nxt_rx[7:0];
  assign wr_frame = frame_done && nxt_rx[15];
  assign rd_frame = frame_done && !nxt_rx[15];
  assign wr_cmd_lo = wr_frame && (f_addr == `GCAS_ADDR_GLOBAL_COMMAND);
  assign wr_cmd_hi = wr_frame && (f_addr == (`GCAS_ADDR_GLOBAL_COMMAND + 7'h01));

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
      rd_addr_ff <= 7'h00;
    else if (rd_frame)
      rd_addr_ff <= {f_addr[6:1], 1'b0};
  end

  // ==========================================================
  // Global command register: one-cycle pulses, never stored
  logic [15:0] cmd_ff;

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
      cmd_ff <= `GCAS_RESET_VALUE;
    else if (wr_cmd_lo)
      cmd_ff <= {8'h00, f_data};
    else if (wr_cmd_hi)
      cmd_ff <= {f_data, 8'h00};
    else
      cmd_ff <= `GCAS_RESET_VALUE;
  end

  assign o_autonull = cmd_ff[`GCAS_CMD_AUTONULL];
  assign o_autonull_clear = cmd_ff[`GCAS_CMD_CLEAR_AUTONULL];
  assign o_load_bands = cmd_ff[`GCAS_CMD_LOAD_BANDS];
  assign o_fetch_record = cmd_ff[`GCAS_CMD_FETCH_RECORD];
  assign o_save_bands = cmd_ff[`GCAS_CMD_SAVE_BANDS];
  assign o_buffer_pointer_zero = cmd_ff[`GCAS_CMD_BUF_PTR_ZERO];
  assign o_clear_bands = cmd_ff[`GCAS_CMD_CLEAR_BANDS];
  assign o_clear_records = cmd_ff[`GCAS_CMD_CLEAR_RECORDS];
  assign o_software_reset = cmd_ff[`GCAS_CMD_SOFT_RESET];
  assign o_save_registers = cmd_ff[`GCAS_CMD_SAVE_REGS];
  assign o_flash_test_start = cmd_ff[`GCAS_CMD_FLASH_TEST];
  assign o_factory_restore = cmd_ff[`GCAS_CMD_FACTORY_RESTORE];
  assign o_buffer_clear = cmd_ff[`GCAS_CMD_FACTORY_RESTORE];
  assign o_self_test_start = cmd_ff[`GCAS_CMD_SELF_TEST];

  // ==========================================================
  // Recording toggle
  gcas_pkg::gcas_rec_state_t rec_ff;

  // Start when idle, stop when active
  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
      rec_ff <= gcas_pkg::GCAS_REC_IDLE;
    else if (cmd_ff[`GCAS_CMD_RECORD_TOGGLE])
    begin
      unique case (rec_ff)
        gcas_pkg::GCAS_REC_IDLE: rec_ff <= gcas_pkg::GCAS_REC_ACTIVE;
        gcas_pkg::GCAS_REC_ACTIVE: rec_ff <= gcas_pkg::GCAS_REC_IDLE;
      endcase
    end
  end

  assign o_recording = (rec_ff == gcas_pkg::GCAS_REC_ACTIVE);
  assign o_record_start = cmd_ff[`GCAS_CMD_RECORD_TOGGLE] && (rec_ff == gcas_pkg::GCAS_REC_IDLE);
  assign o_record_stop = cmd_ff[`GCAS_CMD_RECORD_TOGGLE] && (rec_ff == gcas_pkg::GCAS_REC_ACTIVE);

  // ==========================================================
  // Power-down
  logic pd_ff;

  // Wake on chip select or timer
  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
      pd_ff <= 1'b0;
    else if (cmd_ff[`GCAS_CMD_POWER_DOWN])
      pd_ff <= 1'b1;
    else if (cs_fall || i_auto_timer_fire)
      pd_ff <= 1'b0;
  end

  assign o_power_down = pd_ff;

  // ==========================================================
  // Diagnostic flags; an event in the clearing cycle survives
  logic [15:0] diag_ff;
  logic [15:0] diag_set;

  always_comb
  begin
    diag_set = i_diag_flags;
    diag_set[`GCAS_DIAG_SELF_TEST_ERR] = i_self_test_done && i_self_test_fail;
    diag_set[`GCAS_DIAG_FLASH_TEST_ERR] = i_flash_test_done && i_flash_test_fail;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
      diag_ff <= `GCAS_RESET_VALUE;
    else
    begin
      if (cmd_ff[`GCAS_CMD_DIAG_CLEAR])
        diag_ff <= diag_set;
      else
        diag_ff <= diag_ff | diag_set;
      if (i_flash_test_done)
        diag_ff[`GCAS_DIAG_FLASH_TEST_ERR] <= i_flash_test_fail;
    end
  end

  assign o_diagnostic_status = diag_ff;

  // ==========================================================
  // Alarm status and peak registers
  gcas_pkg::gcas_word_t stat_x;
  gcas_pkg::gcas_word_t stat_y;
  gcas_pkg::gcas_word_t stat_z;
  logic [15:0] stat_x_ff;
  logic [15:0] stat_y_ff;
  logic [15:0] stat_z_ff;
  logic [15:0] peak_x_ff;

  gcas_stat_pack u_pack_x
  (
    .i_alarm1(i_alarm1_x),
    .i_alarm2(i_alarm2_x),
    .i_worst_band(i_worst_band_x),
    .o_word(stat_x)
  );

  gcas_stat_pack u_pack_y
  (
    .i_alarm1(i_alarm1_y),
    .i_alarm2(i_alarm2_y),
    .i_worst_band(i_worst_band_y),
    .o_word(stat_y)
  );

  gcas_stat_pack u_pack_z
  (
    .i_alarm1(i_alarm1_z),
    .i_alarm2(i_alarm2_z),
    .i_worst_band(i_worst_band_z),
    .o_word(stat_z)
  );

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      stat_x_ff <= `GCAS_RESET_VALUE;
      stat_y_ff <= `GCAS_RESET_VALUE;
      stat_z_ff <= `GCAS_RESET_VALUE;
      peak_x_ff <= `GCAS_RESET_VALUE;
    end
    else if (i_alarm_update)
    begin
      stat_x_ff <= stat_x;
      stat_y_ff <= stat_y;
      stat_z_ff <= stat_z;
      peak_x_ff <= i_peak_x;
    end
  end

  // ==========================================================
  // Read data, returned in the frame after the request
  logic [15:0] rd_word;

  always_comb
  begin
    unique case (rd_addr_ff)
      `GCAS_ADDR_ALARM_STATUS_X: rd_word = stat_x_ff;
      `GCAS_ADDR_ALARM_STATUS_Y: rd_word = stat_y_ff;
      `GCAS_ADDR_ALARM_STATUS_Z: rd_word = stat_z_ff;
      `GCAS_ADDR_ALARM_PEAK_X: rd_word = peak_x_ff;
      `GCAS_ADDR_DIAG_STATUS: rd_word = diag_ff;
      default: rd_word = `GCAS_RESET_VALUE;
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
      tx_ff <= `GCAS_RESET_VALUE;
    else if (cs_fall || (state_ff == gcas_pkg::GCAS_SPI_DONE))
      tx_ff <= rd_word;
    else if (sclk_fall && (bit_cnt_ff != 5'h00))
      tx_ff <= {tx_ff[14:0], 1'b0};
  end

  assign o_spi_miso = tx_ff[15];
  assign o_spi_miso_oe_n = cs_n_s;

endmodule // gcas_top

`default_nettype wire

// File: hw/gcas_params.svh
// Register offsets, field positions and widths of the command and alarm block
`ifndef GCAS_PARAMS_SVH
`define GCAS_PARAMS_SVH

// ==========================================================
// Register byte addresses (lower byte of each word)
`define GCAS_ADDR_GLOBAL_COMMAND 7'h3E
`define GCAS_ADDR_ALARM_STATUS_X 7'h40
`define GCAS_ADDR_ALARM_STATUS_Y 7'h42
`define GCAS_ADDR_ALARM_STATUS_Z 7'h44
`define GCAS_ADDR_ALARM_PEAK_X 7'h46
`define GCAS_ADDR_DIAG_STATUS 7'h3C

// ==========================================================
// Command bit positions
`define GCAS_CMD_AUTONULL 0
`define GCAS_CMD_POWER_DOWN 1
`define GCAS_CMD_SELF_TEST 2
`define GCAS_CMD_FACTORY_RESTORE 3
`define GCAS_CMD_DIAG_CLEAR 4
`define GCAS_CMD_FLASH_TEST 5
`define GCAS_CMD_SAVE_REGS 6
`define GCAS_CMD_SOFT_RESET 7
`define GCAS_CMD_CLEAR_RECORDS 8
`define GCAS_CMD_CLEAR_BANDS 9
`define GCAS_CMD_BUF_PTR_ZERO 10
`define GCAS_CMD_RECORD_TOGGLE 11
`define GCAS_CMD_SAVE_BANDS 12
`define GCAS_CMD_FETCH_RECORD 13
`define GCAS_CMD_LOAD_BANDS 14
`define GCAS_CMD_CLEAR_AUTONULL 15

// ==========================================================
// Diagnostic status flag positions and field layouts
`define GCAS_DIAG_SELF_TEST_ERR 5
`define GCAS_DIAG_FLASH_TEST_ERR 6
`define GCAS_STAT_BAND_LSB 4
`define GCAS_STAT_UNUSED_BIT 3
`define GCAS_RESET_VALUE 16'h0000
`define GCAS_WORD_BITS 16
`define GCAS_FRAME_CNT_BITS 5
`define GCAS_BAND_MIN 3'h1
`define GCAS_BAND_MAX 3'h6

`endif

// File: hw/gcas_pkg.sv
// Types shared by the command and alarm block
package gcas_pkg;

  typedef enum logic [1:0] {
    GCAS_SPI_IDLE,
    GCAS_SPI_SHIFT,
    GCAS_SPI_DONE
  } gcas_spi_state_t;

  typedef enum logic {
    GCAS_REC_IDLE,
    GCAS_REC_ACTIVE
  } gcas_rec_state_t;

  typedef logic [15:0] gcas_word_t;

endpackage

// File: hw/gcas_sync.sv
// Two-flop synchroniser for one pin level
`timescale 1ns/100ps
`default_nettype none

module gcas_sync
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_async,
  output logic o_sync
);

  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      // Idle-high level of select and clock, so no false edge follows reset
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
    end
    else
    begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;

endmodule // gcas_sync

`default_nettype wire

// File: hw/gcas_stat_pack.sv
// Packs per-band alarm pairs and worst band number into one status word
`timescale 1ns/100ps
`default_nettype none

`include "gcas_params.svh"

module gcas_stat_pack
(
  input wire logic [5:0] i_alarm1,
  input wire logic [5:0] i_alarm2,
  input wire logic [2:0] i_worst_band,
  output gcas_pkg::gcas_word_t o_word
);

  logic [2:0] band_field;

  // Band number outside 1..6 reads as zero
  assign band_field = ((i_worst_band >= `GCAS_BAND_MIN) && (i_worst_band <= `GCAS_BAND_MAX))
                      ? i_worst_band : 3'h0;

  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1)
    begin : g_band
      assign o_word[`GCAS_STAT_BAND_LSB + 2 * g] = i_alarm1[g];
      assign o_word[`GCAS_STAT_BAND_LSB + 2 * g + 1] = i_alarm2[g];
    end
  endgenerate

  assign o_word[`GCAS_STAT_UNUSED_BIT] = 1'b0;
  assign o_word[2:0] = band_field;

endmodule // gcas_stat_pack

`default_nettype wire

// File: tb/gcas_chk.sv
// Assertion checker for the command and alarm block
`timescale 1ns/100ps
`default_nettype none

module gcas_chk
(
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_spi_cs_n,
  input wire logic i_self_test_done,
  input wire logic i_self_test_fail,
  input wire logic i_flash_test_done,
  input wire logic i_flash_test_fail,
  input wire logic i_auto_timer_fire,
  input wire logic o_autonull,
  input wire logic o_autonull_clear,
  input wire logic o_factory_restore,
  input wire logic o_buffer_clear,
  input wire logic o_record_start,
  input wire logic o_record_stop,
  input wire logic o_recording,
  input wire logic o_power_down,
  input wire logic [15:0] o_diagnostic_status
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);

  // ========================================
  // Sequences and properties
  sequence s_rec_on;
    !o_recording ##1 o_recording;
  endsequence
  sequence s_rec_off;
    o_recording ##1 !o_recording;
  endsequence
  property p_autonull_pulse;
    o_autonull |=> !o_autonull;
  endproperty
  property p_clear_pulse;
    o_autonull_clear |=> !o_autonull_clear;
  endproperty
  property p_restore_pair;
    o_factory_restore |-> o_buffer_clear;
  endproperty
  property p_rec_start;
    o_record_start |-> s_rec_on;
  endproperty
  property p_rec_stop;
    o_record_stop |-> s_rec_off;
  endproperty
  property p_cs_wake;
    o_power_down && $fell(i_spi_cs_n) |-> ##[1:6] !o_power_down;
  endproperty
  property p_timer_wake;
    o_power_down && i_auto_timer_fire |-> ##[1:2] !o_power_down;
  endproperty
  property p_self_fail;
    i_self_test_done && i_self_test_fail |-> ##[1:2] o_diagnostic_status[5];
  endproperty
  property p_flash_fail;
    i_flash_test_done && i_flash_test_fail |-> ##[1:2] o_diagnostic_status[6];
  endproperty
  property p_flash_pass;
    i_flash_test_done && !i_flash_test_fail |=> !o_diagnostic_status[6];
  endproperty

  a_autonull_pulse: assert property (p_autonull_pulse)
    else $error("autonull pulse too long");
  a_clear_pulse: assert property (p_clear_pulse)
    else $error("autonull clear pulse too long");
  a_restore_pair: assert property (p_restore_pair)
    else $error("restore without buffer clear");
  a_rec_start: assert property (p_rec_start)
    else $error("record start did not start");
  a_rec_stop: assert property (p_rec_stop)
    else $error("record stop did not stop");
  a_cs_wake: assert property (p_cs_wake)
    else $error("no wake on select");
  a_timer_wake: assert property (p_timer_wake)
    else $error("no wake on timer");
  a_self_fail: assert property (p_self_fail)
    else $error("self test flag missing");
  a_flash_fail: assert property (p_flash_fail)
    else $error("flash test flag missing");
  a_flash_pass: assert property (p_flash_pass)
    else $error("flash test flag kept after pass");
endmodule // gcas_chk

bind gcas_top gcas_chk chk (.i_clock, .i_reset_n, .i_spi_cs_n, .i_self_test_done,
  .i_self_test_fail, .i_flash_test_done, .i_flash_test_fail, .i_auto_timer_fire,
  .o_autonull, .o_autonull_clear, .o_factory_restore, .o_buffer_clear, .o_record_start,
  .o_record_stop, .o_recording, .o_power_down, .o_diagnostic_status);

`default_nettype wire

// File: tb/gcas_host_model.sv
// Host model driving the serial register link
`timescale 1ns/100ps
`default_nettype none

module gcas_host_model
(
  input wire logic i_clock,
  output logic o_spi_cs_n,
  output logic o_spi_sclk,
  output logic o_spi_mosi,
  input wire logic i_spi_miso
);
  initial
  begin
    o_spi_cs_n = 1'b1;
    o_spi_sclk = 1'b1;
    o_spi_mosi = 1'b0;
  end

  // ========================================
  // One 16-bit frame, MSB first, link clock idle high
  task automatic half();
    repeat (4) @(posedge i_clock);
  endtask

  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    o_spi_cs_n <= 1'b0;
    half();
    for (int i = 15; i >= 0; i--)
    begin
      o_spi_sclk <= 1'b0;
      o_spi_mosi <= tx[i];
      half();
      o_spi_sclk <= 1'b1;
      repeat (3) @(posedge i_clock);
      rx[i] = i_spi_miso;
      @(posedge i_clock);
    end
    o_spi_cs_n <= 1'b1;
    o_spi_mosi <= ~tx[0];
    half();
  endtask
endmodule // gcas_host_model

`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the command and alarm block
`timescale 1ns/100ps
`default_nettype none

`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %0t mismatch got %0h exp %0h", $time, g, e); end end

module tb;
  logic i_clock = 1'b0, i_reset_n = 1'b0, i_spi_cs_n, i_spi_sclk, i_spi_mosi;
  logic [5:0] a1x = 6'h01, a2x = 6'h20, a1y = 6'h2A, a2y = 6'h15, a1z = 6'h3F, a2z = 6'h00;
  logic [2:0] wbx = 3'h6, wby = 3'h1, wbz = 3'h7;
  logic [15:0] i_peak_x = 16'hA5C3, i_diag_flags = 16'h0000, o_diagnostic_status, pv;
  logic i_alarm_update = 1'b0, i_self_test_done = 1'b0, i_self_test_fail = 1'b0;
  logic i_flash_test_done = 1'b0, i_flash_test_fail = 1'b0, i_auto_timer_fire = 1'b0;
  logic o_spi_miso, o_autonull, o_autonull_clear, o_self_test_start, o_factory_restore;
  logic o_buffer_clear, o_flash_test_start, o_save_registers, o_software_reset;
  logic o_clear_records, o_clear_bands, o_record_start, o_record_stop, o_save_bands;
  logic o_fetch_record, o_load_bands, o_buffer_pointer_zero, o_recording, o_power_down;
  logic pd_q = 1'b0, miso_oe_n;
  int cnt [16] = '{default: 0};
  int fails = 0;
  int checks_done = 0;

  initial
  begin
    forever #10 i_clock = ~i_clock;
  end

  gcas_host_model host (.i_clock, .o_spi_cs_n(i_spi_cs_n), .o_spi_sclk(i_spi_sclk),
    .o_spi_mosi(i_spi_mosi), .i_spi_miso(o_spi_miso));

  gcas_top DUT (.i_clock, .i_reset_n, .i_spi_cs_n, .i_spi_sclk, .i_spi_mosi, .o_spi_miso,
    .o_spi_miso_oe_n(miso_oe_n), .i_alarm1_x(a1x), .i_alarm2_x(a2x), .i_worst_band_x(wbx),
    .i_alarm1_y(a1y), .i_alarm2_y(a2y), .i_worst_band_y(wby), .i_alarm1_z(a1z),
    .i_alarm2_z(a2z), .i_worst_band_z(wbz), .i_peak_x, .i_alarm_update, .i_self_test_done,
    .i_self_test_fail, .i_flash_test_done, .i_flash_test_fail, .i_diag_flags,
    .i_auto_timer_fire, .o_autonull, .o_autonull_clear, .o_self_test_start,
    .o_factory_restore, .o_buffer_clear, .o_flash_test_start, .o_save_registers,
    .o_software_reset, .o_clear_records, .o_clear_bands, .o_record_start, .o_record_stop,
    .o_save_bands, .o_fetch_record, .o_load_bands, .o_buffer_pointer_zero, .o_recording,
    .o_power_down, .o_diagnostic_status);

  // ========================================
  // Pulse counters, one per command bit; bit 4 (diagnostic clear) is tied to zero and never counts
  assign pv = {o_autonull_clear, o_load_bands, o_fetch_record, o_save_bands,
    o_record_start | o_record_stop, o_buffer_pointer_zero, o_clear_bands, o_clear_records,
    o_software_reset, o_save_registers, o_flash_test_start, 1'b0, o_factory_restore,
    o_self_test_start, o_power_down & ~pd_q, o_autonull};
  always @(posedge i_clock)
  begin
    pd_q <= o_power_down;
    for (int i = 0; i < 16; i++)
      cnt[i] <= cnt[i] + int'(pv[i]);
  end

  // ========================================
  // Access tasks
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] r;
    host.xfer({1'b1, a, d}, r);
  endtask

  task automatic rchk(input logic [6:0] a, input logic [15:0] e);
    logic [15:0] d;
    host.xfer({1'b0, a, 8'h00}, d);
    host.xfer(16'h0000, d);
    `CHK(d, e)
  endtask

  task automatic cmd(input logic [15:0] m);
    int base [16];
    base = cnt;
    if (m[7:0] != 8'h00 || m == 16'h0000) wr(7'h3E, m[7:0]);
    if (m[15:8] != 8'h00) wr(7'h3F, m[15:8]);
    repeat (8) @(posedge i_clock);
    for (int i = 0; i < 16; i++)
      `CHK(cnt[i] - base[i], (i == 4) ? 0 : int'(m[i]))
  endtask

  function automatic logic [15:0] pack(input logic [5:0] p, q, input logic [2:0] b);
    logic [15:0] w;
    w = 16'h0000;
    for (int i = 0; i < 6; i++)
      w[4 + 2 * i +: 2] = {q[i], p[i]};
    w[2:0] = (b >= 3'h1 && b <= 3'h6) ? b : 3'h0;
    return w;
  endfunction

  task automatic summarize();
    if (fails == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (100000) @(posedge i_clock);
    fails++;
    $display("[ERR] %0t timeout", $time);
    summarize();
  end

  // ========================================
  // Main sequence
  initial
  begin
    repeat (12) @(posedge i_clock);
    i_reset_n <= 1'b1;
    repeat (4) @(posedge i_clock);
    `CHK(miso_oe_n, 1'b1)
    for (int a = 0; a < 4; a++)
      rchk(7'h40 + 7'(2 * a), 16'h0000);
    for (int b = 0; b < 8; b++)
      cmd(16'h0001 << b);
    for (int b = 8; b < 16; b++)
      cmd(16'h0001 << b);
    `CHK(o_recording, 1'b1)
    cmd(16'h0C05);
    `CHK(o_recording, 1'b0)
    cmd(16'h0000);
    cmd(16'h0002);
    `CHK(o_power_down, 1'b1)
    @(posedge i_clock);
    i_auto_timer_fire <= 1'b1;
    @(posedge i_clock);
    i_auto_timer_fire <= 1'b0;
    repeat (3) @(posedge i_clock);
    `CHK(o_power_down, 1'b0)
    cmd(16'h0002);
    rchk(7'h50, 16'h0000);
    `CHK(o_power_down, 1'b0)
    @(posedge i_clock);
    i_alarm_update <= 1'b1;
    i_self_test_done <= 1'b1;
    i_self_test_fail <= 1'b1;
    i_diag_flags <= 16'h0001;
    @(posedge i_clock);
    i_alarm_update <= 1'b0;
    i_self_test_done <= 1'b0;
    i_diag_flags <= 16'h0000;
    i_flash_test_done <= 1'b1;
    i_flash_test_fail <= 1'b1;
    @(posedge i_clock);
    i_flash_test_done <= 1'b0;
    wr(7'h40, 8'hFF);
    rchk(7'h40, pack(a1x, a2x, wbx));
    rchk(7'h42, pack(a1y, a2y, wby));
    rchk(7'h44, pack(a1z, a2z, wbz));
    rchk(7'h46, 16'hA5C3);
    rchk(7'h3C, 16'h0061);
    @(posedge i_clock);
    i_flash_test_fail <= 1'b0;
    i_flash_test_done <= 1'b1;
    @(posedge i_clock);
    i_flash_test_done <= 1'b0;
    rchk(7'h3C, 16'h0021);
    cmd(16'h0010);
    rchk(7'h3C, 16'h0000);
    @(posedge i_clock);
    i_flash_test_done <= 1'b1;
    i_self_test_done <= 1'b1;
    @(posedge i_clock);
    i_flash_test_done <= 1'b0;
    i_self_test_done <= 1'b0;
    rchk(7'h3C, 16'h0020);
    summarize();
  end
endmodule // tb

`default_nettype wire
